// [bench/test_counter_array_waveform_modes.sv]
// Self-checking bench for the waveform bank: registers, PWM, frequency and clock source.
`timescale 1ns/1ns
module test_counter_array_waveform_modes
	import wave_pkg::*;
;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic ext_tick = 1'b0;
	logic clr = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [NUM_MOD-1:0] waveform_pin;
	logic irq_req;
	int high_cnt;
	int rise_cnt;
	int num_errors = 0;
	int n_checks = 0;
	logic [31:0] rnd = 32'h9d12_689b;
	logic [32:0] exp_q[$];
	logic [31:0] mask_q[$];

	always #5 sys_clk = ~sys_clk;

	wave_bank DUT (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ext_tick(ext_tick),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .waveform_pin(waveform_pin),
		.irq_req(irq_req));
	wave_load LOAD (.sys_clk(sys_clk), .clr(clr), .sel(sel), .pins(waveform_pin),
		.high_cnt(high_cnt), .rise_cnt(rise_cnt));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] ma(input int n, input logic [3:0] ofs);
		return 8'h10 + 8'(n * 16) + {4'h0, ofs};
	endfunction

	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		n_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
		end
	endtask

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		if (i == 16) num_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// The expected value and mask are queued first; the monitor compares at completion.
	task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		mask_q.push_back(m);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic meas(input int s, input int n);
		@(posedge sys_clk);
		sel <= 3'(s);
		@(posedge sys_clk);
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		repeat (n - 1) @(posedge sys_clk);
		#1;
	endtask

	task automatic restart(input logic [15:0] c);
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_COUNT, {16'h0000, c});
	endtask

	always @(posedge sys_clk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			check({pslverr, prdata & mask_q.pop_front()}, exp_q.pop_front());
		end
	end

	initial begin
		#600_000;
		num_errors++;
		give_verdict();
	end

	initial begin
		logic [7:0] h;
		logic [15:0] w;
		int heff;
		int p;
		int v;
		int nt;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		rd(ADDR_CTRL, 33'h0, 32'h0000_00ff);
		rd(ADDR_AMODE, {30'h0, SRC_RST}, 32'h0000_0007);
		rd(ADDR_PWMCFG, {31'h0, CLS_RST}, 32'h0000_00a3);
		rd(ADDR_COUNT, {17'h0, COUNT_RST}, 32'h0000_ffff);
		rd(ma(0, OFS_MODE), {25'h0, MODE_RST}, 32'h0000_00ff);
		rd(8'hf0, 33'h1_0000_0000, 32'h0000_0000);
		rd(8'h02, 33'h1_0000_0000, 32'h0000_0000);
		wr(ADDR_AMODE, {29'h0, SRC_SYS});
		wr(ma(1, OFS_MODE), 32'h0000_0004);
		wr(ma(1, OFS_CPH), 32'h0000_0010);
		rd(ma(1, OFS_MODE), 33'h44, 32'h0000_00ff);
		wr(ma(1, OFS_CPL), 32'h0000_0010);
		rd(ma(1, OFS_MODE), 33'h04, 32'h0000_00ff);
		for (int i = 0; i < 3; i++) begin
			h = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[7:0];
			rnd = lfsr(rnd);
			restart(16'h0000);
			wr(ADDR_PWMCFG, {30'h0, CLS_8});
			wr(ma(0, OFS_MODE), 32'h0000_004c);
			// low byte first; the wrong low byte is replaced by reload.
			wr(ma(0, OFS_CPL), {24'h0, ~h});
			wr(ma(0, OFS_CPH), {24'h0, h});
			wr(ADDR_CTRL, 32'h0000_0040);
			repeat (300) @(posedge sys_clk);
			meas(0, 512);
			check(33'(high_cnt), 33'(2 * (256 - h)));
			check(33'(rise_cnt), (h == 8'h00) ? 33'h0 : 33'h2);
			meas(1, 256);
			check(33'(high_cnt), 33'h0);
			rd(ADDR_CTRL, 33'h1, 32'h0000_0001);
			rd(ADDR_PWMCFG, 33'h20, 32'h0000_0020);
		end
		for (int i = 0; i < 2; i++) begin
			h = (i == 0) ? 8'h00 : 8'h05;
			heff = (h == 8'h00) ? 256 : int'(h);
			restart(16'h0000);
			wr(ma(2, OFS_MODE), 32'h0000_004e);
			wr(ma(2, OFS_CPL), 32'h0000_0000);
			wr(ma(2, OFS_CPH), {24'h0, h});
			wr(ADDR_CTRL, 32'h0000_0040);
			repeat (1600) @(posedge sys_clk);
			meas(2, 8 * heff);
			check(33'(high_cnt), 33'(4 * heff));
			check(33'(rise_cnt), 33'h4);
			rd(ADDR_CTRL, (h == 8'h05) ? 33'h4 : 33'h0, 32'h0000_0004);
		end
		for (int c = 1; c < 4; c++) begin
			p = 256 << c;
			w = rnd[15:0] | 16'hf800;
			rnd = lfsr(rnd);
			v = int'(w) & (p - 1);
			restart(16'h0000);
			wr(ma(4, OFS_MODE), 32'h0000_004c);
			wr(ADDR_PWMCFG, 32'h0000_0080 | c);
			wr(ma(4, OFS_CPL), {24'h0, w[7:0]});
			wr(ma(4, OFS_CPH), {24'h0, w[15:8]});
			rd(ma(4, OFS_CPL), {25'h0, w[7:0]}, 32'h0000_00ff);
			wr(ADDR_PWMCFG, 32'(c));
			wr(ma(4, OFS_CPL), 32'h0000_0000);
			wr(ma(4, OFS_CPH), 32'h0000_0000);
			rd(ma(4, OFS_CPL), 33'h0, 32'h0000_00ff);
			wr(ADDR_CTRL, 32'h0000_0040);
			repeat (p + 50) @(posedge sys_clk);
			meas(4, p);
			check(33'(high_cnt), 33'(p - v));
			check(33'(rise_cnt), (v == 0) ? 33'h0 : 33'h1);
			rd(ADDR_CTRL, 33'h10, 32'h0000_0010);
			rd(ADDR_PWMCFG, 33'h20, 32'h0000_0020);
		end
		restart(16'hff00);
		wr(ma(3, OFS_MODE), 32'h0000_00cd);
		wr(ma(3, OFS_CPL), 32'h0000_00f0);
		wr(ma(3, OFS_CPH), 32'h0000_00ff);
		wr(ADDR_CTRL, 32'h0000_0040);
		meas(3, 300);
		check(33'(high_cnt), 33'h10);
		check(33'(rise_cnt), 33'h1);
		check(33'(irq_req), 33'h1);
		rd(ADDR_CTRL, 33'h88, 32'h0000_0088);
		wr(ADDR_CTRL, 32'h0000_0040);
		repeat (3) @(posedge sys_clk);
		#1;
		check(33'(irq_req), 33'h0);
		restart(16'h0000);
		wr(ADDR_AMODE, {29'h0, SRC_EXT});
		wr(ADDR_CTRL, 32'h0000_0040);
		nt = 0;
		repeat (200) begin
			@(posedge sys_clk);
			ext_tick <= rnd[0];
			nt += int'(rnd[0]);
			rnd = lfsr(rnd);
		end
		@(posedge sys_clk);
		ext_tick <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(ADDR_COUNT, 33'(nt), 32'h0000_ffff);
		wr(ma(5, OFS_MODE), 32'h0000_0002);
		wr(ma(5, OFS_CPH), 32'h0000_0001);
		// Module 2 still toggles every 5 counter clocks, so its period shows the divider.
		for (int s = 0; s < 2; s++) begin
			nt = (s == 0) ? 4 : 12;
			wr(ADDR_AMODE, (s == 0) ? {29'h0, SRC_DIV4} : {29'h0, SRC_DIV12});
			repeat ((s == 0) ? 1200 : 200) @(posedge sys_clk);
			meas(2, 40 * nt);
			check(33'(high_cnt), 33'(20 * nt));
			check(33'(rise_cnt), 33'h4);
		end
		meas(5, 100);
		check(33'(high_cnt), 33'h0);
		give_verdict();
	end
endmodule // test_counter_array_waveform_modes

// [bench/wave_load.sv]
// Passive load on the waveform pins that counts high samples and rising edges of one pin.
`timescale 1ns/1ns
module wave_load (
	input wire logic sys_clk,
	input wire logic clr,
	input wire logic [2:0] sel,
	input wire logic [5:0] pins,
	output int high_cnt,
	output int rise_cnt
);
	logic prev_q;
	// The previous level survives a clear, so an edge on the first sample still counts.
	always @(posedge sys_clk) begin
		prev_q <= pins[sel];
		high_cnt <= (clr ? 0 : high_cnt) + int'(pins[sel]);
		rise_cnt <= (clr ? 0 : rise_cnt) + int'(pins[sel] && !prev_q);
	end
endmodule // wave_load

// [logic/wave_bank.sv]
// Bank of compare modules producing square waves and PWM on a shared counter.
//
// Contract
// (RULE1) Frequency mode: high byte is counts between toggles; zero acts as 256.
// (RULE2) Frequency mode: low-byte match toggles pin and adds high byte to low byte.
// (RULE3) Frequency mode needs compare, toggle and PWM enables all set.
// (RULE4) Frequency mode with match flag enable flags full 16-bit equality.
// (RULE5) All 8 to 11-bit PWM modules share one cycle length setting.
// (RULE6) 8-bit PWM: low-byte match drives pin high.
// (RULE7) 8-bit PWM: low-byte wrap drives pin low and reloads low from high byte.
// (RULE8) 8-bit PWM needs compare and PWM enables with cycle length 00.
// (RULE9) 8-bit PWM: match sets event flag if enabled; wrap sets cycle overflow flag.
// (RULE10) Writing low byte clears compare enable; writing high byte sets it.
// (RULE11) Software should write low byte before high byte.
// (RULE12) Compare enable clear in PWM modes keeps pin low.
// (RULE13) 8-bit duty equals 256 minus high byte, over 256.
// (RULE14) Reload access select steers byte accesses to shadow or compare register.
// (RULE15) N-bit PWM: N-bit match sets pin; overflow clears pin, flags, reloads.
// (RULE16) Cycle length select picks N; overflow every 512, 1024 or 2048 clocks.
// (RULE17) 9 to 11-bit PWM selected by enables and non-8-bit length; match flags.
// (RULE18) 16-bit PWM: full match sets pin; counter overflow clears it and flags.
// (RULE19) 16-bit PWM needs wide enable too and ignores shared cycle length.
// (RULE20) 16-bit PWM with match flag enable flags each full match.
// (RULE21) Software should time 16-bit duty updates to match interrupts.
// (RULE22) Counter clock comes from the clock source select field.
// (RULE23) Event flags clear only by software; interrupt while flag and enable set.
// (RULE24) One shared 16-bit counter steps per counter clock, wrapping to zero.
// (RULE25) N-bit compare values are right-justified; upper bits are ignored.
`timescale 1ns/1ns
module wave_bank
	import wave_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic ext_tick,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [NUM_MOD-1:0] waveform_pin,
	output logic irq_req
);
	// (RULE16) Length select picks N.
	function automatic logic [15:0] len_mask(input logic [1:0] cls);
		logic [15:0] m;
		unique case (cls)
			CLS_8: m = MASK_8;
			CLS_9: m = MASK_9;
			CLS_10: m = MASK_10;
			CLS_11: m = MASK_11;
		endcase
		return m;
	endfunction
	function automatic wave_mode_e mode_of(input logic [7:0] m, input logic [1:0] cls);
		wave_mode_e r;
		r = WM_OFF;
		// (RULE3) Frequency output decode.
		if (m[MODE_PWM] && m[MODE_TOG]) begin
			r = WM_FREQ;
		// (RULE19) Wide PWM ignores length.
		end else if (m[MODE_PWM] && m[MODE_WIDE]) begin
			r = WM_PWM16;
		// (RULE8) Eight-bit at length zero.
		end else if (m[MODE_PWM] && cls == CLS_8) begin
			r = WM_PWM8;
		end else if (m[MODE_PWM]) begin
			r = WM_PWM_ENABLE;
		end
		return r;
	endfunction
	function automatic logic mod_hit(input logic [7:0] a);
		return a[7:4] >= 4'h1 && a[7:4] <= MOD_LAST && a[1:0] == 2'h0 && a[3:2] != 2'h3;
	endfunction
	logic [5:0] event_flag_q;
	logic run_q;
	logic cf_q;
	logic [2:0] src_q;
	logic [1:0] cls_q;
	logic cycle_overflow_flag_q;
	logic reload_access_select_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_nxt;
	logic [3:0] div_q;
	logic tick_q;
	logic adv;
	logic [7:0] mode_q [NUM_MOD];
	logic [7:0] cpl_q [NUM_MOD];
	logic [7:0] cph_q [NUM_MOD];
	logic [7:0] arl_q [NUM_MOD];
	logic [7:0] arh_q [NUM_MOD];
	wave_mode_e wmode [NUM_MOD];
	logic [NUM_MOD-1:0] pwm_match;
	logic [NUM_MOD-1:0] full_hit;
	logic [NUM_MOD-1:0] freq_hit;
	logic [NUM_MOD-1:0] ev_set;
	logic [15:0] mask;
	logic wrap_n;
	logic wr;
	logic [3:0] sub;
	int midx;
	logic mhit;
	logic [31:0] rd_d;
	logic err_d;
	assign wr = psel && penable && pready && pwrite;
	assign sub = paddr[3:0];
	assign midx = int'(paddr[7:4]) - 1;
	assign mhit = mod_hit(paddr);
	assign adv = run_q && tick_q;
	assign cnt_nxt = cnt_q + 16'h0001;
	// (RULE5) One shared length mask.
	assign mask = len_mask(cls_q);
	assign wrap_n = (cnt_nxt & mask) == 16'h0000;
	// The slave answers in the first access cycle, so every transfer takes two cycles.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			if (psel && !penable) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr <= err_d;
			end
		end
	end
	always_comb begin
		rd_d = 32'h0000_0000;
		err_d = 1'b0;
		if (paddr == ADDR_CTRL) begin
			rd_d = {24'h00_0000, cf_q, run_q, event_flag_q};
		end else if (paddr == ADDR_AMODE) begin
			rd_d = {29'h0000_0000, src_q};
		end else if (paddr == ADDR_PWMCFG) begin
			rd_d = {24'h00_0000, reload_access_select_q, 1'b0, cycle_overflow_flag_q, 3'h0, cls_q};
		end else if (paddr == ADDR_COUNT) begin
			rd_d = {16'h0000, cnt_q};
		end else if (mhit) begin
			// (RULE14) Reads follow the access select.
			if (sub == OFS_MODE) begin
				rd_d = {24'h00_0000, mode_q[midx]};
			end else if (sub == OFS_CPL) begin
				rd_d = {24'h00_0000, reload_access_select_q ? arl_q[midx] : cpl_q[midx]};
			end else begin
				rd_d = {24'h00_0000, reload_access_select_q ? arh_q[midx] : cph_q[midx]};
			end
		end else begin
			err_d = 1'b1;
		end
	end
	// (RULE22) Counter clock source select.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			div_q <= 4'h0;
			tick_q <= 1'b0;
		end else begin
			div_q <= (div_q == DIV12_LAST) ? 4'h0 : div_q + 4'h1;
			unique case (src_q)
				SRC_DIV4: tick_q <= div_q[1:0] == DIV4_LAST;
				SRC_EXT: tick_q <= ext_tick;
				SRC_SYS: tick_q <= 1'b1;
				default: tick_q <= div_q == DIV12_LAST;
			endcase
		end
	end
	// (RULE24) Shared counter steps and wraps.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= COUNT_RST;
		end else if (wr && paddr == ADDR_COUNT) begin
			cnt_q <= pwdata[15:0];
		end else if (adv) begin
			cnt_q <= cnt_nxt;
		end
	end
	// Match decode is taken on the next count so a match and a wrap on one step
	// resolve with the match winning, which gives the full-duty case.
	always_comb begin
		for (int i = 0; i < NUM_MOD; i++) begin
			logic [15:0] eff;
			eff = {cph_q[i], cpl_q[i]};
			wmode[i] = mode_of(mode_q[i], cls_q);
			if (wrap_n && wmode[i] == WM_PWM8) begin
				eff = {8'h00, cph_q[i]};
			end else if (wrap_n && wmode[i] == WM_PWM_ENABLE) begin
				eff = {arh_q[i], arl_q[i]};
			end
			// (RULE25) Upper bits are masked off.
			pwm_match[i] = ((cnt_nxt ^ eff) & mask) == 16'h0000;
			full_hit[i] = cnt_nxt == {cph_q[i], cpl_q[i]};
			freq_hit[i] = cnt_nxt[7:0] == cpl_q[i];
			ev_set[i] = 1'b0;
			if (adv && mode_q[i][MODE_ECOM] && mode_q[i][MODE_MAT]) begin
				unique case (wmode[i])
					// (RULE4) Full equality in frequency mode.
					WM_FREQ: ev_set[i] = full_hit[i];
					// (RULE17) Rising-edge match flags.
					WM_PWM8, WM_PWM_ENABLE: ev_set[i] = pwm_match[i];
					// (RULE20) Wide match flags.
					WM_PWM16: ev_set[i] = full_hit[i];
					WM_OFF: ev_set[i] = 1'b0;
				endcase
			end
		end
	end
	// (RULE10) Byte writes steer compare enable.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_MOD; i++) begin
				mode_q[i] <= MODE_RST;
			end
		end else if (wr && mhit) begin
			if (sub == OFS_MODE) begin
				mode_q[midx] <= pwdata[7:0];
			end else if (sub == OFS_CPL) begin
				mode_q[midx][MODE_ECOM] <= 1'b0;
			end else begin
				mode_q[midx][MODE_ECOM] <= 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_MOD; i++) begin
				cpl_q[i] <= BYTE_RST;
				cph_q[i] <= BYTE_RST;
				arl_q[i] <= BYTE_RST;
				arh_q[i] <= BYTE_RST;
			end
		end else begin
			for (int i = 0; i < NUM_MOD; i++) begin
				if (wr && mhit && midx == i && sub != OFS_MODE) begin
					// (RULE14) Writes follow the access select.
					if (sub == OFS_CPL && reload_access_select_q) begin
						arl_q[i] <= pwdata[7:0];
					end else if (sub == OFS_CPL) begin
						cpl_q[i] <= pwdata[7:0];
					end else if (reload_access_select_q) begin
						arh_q[i] <= pwdata[7:0];
					end else begin
						cph_q[i] <= pwdata[7:0];
					end
				end else if (adv) begin
					unique case (wmode[i])
						WM_FREQ: begin
							// (RULE1) Eight-bit add makes zero a full 256 step.
							if (mode_q[i][MODE_ECOM] && freq_hit[i]) begin
								cpl_q[i] <= cpl_q[i] + cph_q[i];
							end
						end
						WM_PWM8: begin
							// (RULE7) Low byte reloads at wrap.
							if (wrap_n) begin
								cpl_q[i] <= cph_q[i];
							end
						end
						WM_PWM_ENABLE: begin
							// (RULE15) Shadow loads at overflow.
							if (wrap_n) begin
								cpl_q[i] <= arl_q[i];
								cph_q[i] <= arh_q[i];
							end
						end
						WM_PWM16, WM_OFF: ;
					endcase
				end
			end
		end
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			waveform_pin <= '0;
		end else begin
			for (int i = 0; i < NUM_MOD; i++) begin
				unique case (wmode[i])
					WM_FREQ: begin
						// (RULE2) Toggle on low-byte match.
						if (adv && mode_q[i][MODE_ECOM] && freq_hit[i]) begin
							waveform_pin[i] <= !waveform_pin[i];
						end
					end
					WM_PWM8, WM_PWM_ENABLE: begin
						// (RULE12) Disabled compare means zero duty.
						if (!mode_q[i][MODE_ECOM]) begin
							waveform_pin[i] <= 1'b0;
						// (RULE13) Rise at match, fall at wrap.
						// (RULE6) Match raises pin.
						end else if (adv && pwm_match[i]) begin
							waveform_pin[i] <= 1'b1;
						end else if (adv && wrap_n) begin
							waveform_pin[i] <= 1'b0;
						end
					end
					WM_PWM16: begin
						// (RULE18) Wide PWM edges.
						if (!mode_q[i][MODE_ECOM]) begin
							waveform_pin[i] <= 1'b0;
						end else if (adv && full_hit[i]) begin
							waveform_pin[i] <= 1'b1;
						end else if (adv && cnt_nxt == 16'h0000) begin
							waveform_pin[i] <= 1'b0;
						end
					end
					WM_OFF: waveform_pin[i] <= 1'b0;
				endcase
			end
		end
	end
	// (RULE23) Flags set by hardware, cleared only by writing zero; set wins.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			event_flag_q <= 6'h00;
			cf_q <= 1'b0;
			run_q <= 1'b0;
		end else if (wr && paddr == ADDR_CTRL) begin
			event_flag_q <= (event_flag_q & pwdata[5:0]) | ev_set;
			cf_q <= (cf_q && pwdata[CTRL_CF]) || (adv && cnt_nxt == 16'h0000);
			run_q <= pwdata[CTRL_RUN];
		end else begin
			event_flag_q <= event_flag_q | ev_set;
			cf_q <= cf_q || (adv && cnt_nxt == 16'h0000);
		end
	end
	// (RULE9) Cycle overflow flag on every N-bit wrap.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cycle_overflow_flag_q <= 1'b0;
			cls_q <= CLS_RST;
			reload_access_select_q <= 1'b0;
			src_q <= SRC_RST;
		end else begin
			if (wr && paddr == ADDR_PWMCFG) begin
				cycle_overflow_flag_q <= (cycle_overflow_flag_q && pwdata[PCFG_CYCLE_OVERFLOW_FLAG]) || (adv && wrap_n);
				cls_q <= pwdata[PCFG_CLS_LO +: 2];
				reload_access_select_q <= pwdata[PCFG_RELOAD_ACCESS_SELECT];
			end else begin
				cycle_overflow_flag_q <= cycle_overflow_flag_q || (adv && wrap_n);
			end
			if (wr && paddr == ADDR_AMODE) begin
				src_q <= pwdata[2:0];
			end
		end
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= 1'b0;
			for (int i = 0; i < NUM_MOD; i++) begin
				if (event_flag_q[i] && mode_q[i][MODE_IRQ_EN]) begin
					irq_req <= 1'b1;
				end
			end
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	a_low_write_clear: assert property ( // (RULE10)
		wr && paddr == 8'h14 |=> !mode_q[0][MODE_ECOM]) else $error("low write kept enable");
	a_high_write_set: assert property ( // (RULE10)
		wr && paddr == 8'h18 |=> mode_q[0][MODE_ECOM]) else $error("high write left enable off");
	a_pwm_off_low: assert property ( // (RULE12)
		(wmode[0] == WM_PWM8 || wmode[0] == WM_PWM_ENABLE) && !mode_q[0][MODE_ECOM] |=> !waveform_pin[0])
		else $error("disabled PWM pin not low");
	a_freq_toggle: assert property ( // (RULE2)
		adv && wmode[0] == WM_FREQ && mode_q[0][MODE_ECOM] && freq_hit[0] && !wr
		|=> waveform_pin[0] != $past(waveform_pin[0]) && cpl_q[0] == $past(cpl_q[0] + cph_q[0]))
		else $error("frequency toggle or step wrong");
	a_eight_fall: assert property ( // (RULE7)
		adv && wmode[0] == WM_PWM8 && mode_q[0][MODE_ECOM] && wrap_n && cph_q[0] != 8'h00 && !wr
		|=> !waveform_pin[0] && cpl_q[0] == $past(cph_q[0])) else $error("8-bit wrap wrong");
	a_eight_rise: assert property ( // (RULE6)
		adv && wmode[0] == WM_PWM8 && mode_q[0][MODE_ECOM] && pwm_match[0] |=> waveform_pin[0])
		else $error("8-bit match did not raise pin");
	a_cycle_ovf: assert property ( // (RULE16)
		adv && wrap_n |=> cycle_overflow_flag_q) else $error("cycle overflow flag missed");
	a_wide_fall: assert property ( // (RULE18)
		adv && cnt_nxt == 16'h0000 && wmode[0] == WM_PWM16 && mode_q[0][MODE_ECOM] && !full_hit[0]
		|=> !waveform_pin[0] && cf_q) else $error("16-bit overflow wrong");
	a_wide_event: assert property ( // (RULE20)
		adv && wmode[0] == WM_PWM16 && mode_q[0][MODE_ECOM] && mode_q[0][MODE_MAT] && full_hit[0]
		|=> event_flag_q[0]) else $error("16-bit match flag missed");
	a_irq_level: assert property ( // (RULE23)
		event_flag_q[3] && mode_q[3][MODE_IRQ_EN] && !wr |=> irq_req && event_flag_q[3])
		else $error("irq or flag dropped");
	a_count_step: assert property ( // (RULE24)
		adv && !(wr && paddr == ADDR_COUNT) |=> cnt_q == $past(cnt_nxt)) else $error("counter step");

	c_freq_run: cover property (wmode[0] == WM_FREQ && adv && freq_hit[0] ##1 waveform_pin[0]);
	c_pwm8_cycle: cover property (wmode[0] == WM_PWM8 && waveform_pin[0] ##[1:600] !waveform_pin[0]);
	c_pwm_enable_reload: cover property (wmode[0] == WM_PWM_ENABLE && adv && wrap_n);
	c_wide_flag: cover property (wmode[3] == WM_PWM16 && ev_set[3]);

endmodule // wave_bank

// [logic/wave_pkg.sv]
// Constants, register map and mode encodings for the waveform bank.
package wave_pkg;
	localparam int NUM_MOD = 6;
	localparam logic [3:0] MOD_LAST = 4'h6;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_AMODE = 8'h04;
	localparam logic [7:0] ADDR_PWMCFG = 8'h08;
	localparam logic [7:0] ADDR_COUNT = 8'h0c;
	localparam logic [3:0] OFS_MODE = 4'h0;
	localparam logic [3:0] OFS_CPL = 4'h4;
	localparam logic [3:0] OFS_CPH = 4'h8;
	// Control register fields.
	localparam int CTRL_RUN = 6;
	localparam int CTRL_CF = 7;
	// Configuration register fields.
	localparam int PCFG_CLS_LO = 0;
	localparam int PCFG_CYCLE_OVERFLOW_FLAG = 5;
	localparam int PCFG_RELOAD_ACCESS_SELECT = 7;
	// Module mode register fields.
	localparam int MODE_IRQ_EN = 0;
	localparam int MODE_TOG = 1;
	localparam int MODE_PWM = 2;
	localparam int MODE_MAT = 3;
	localparam int MODE_ECOM = 6;
	localparam int MODE_WIDE = 7;
	// Reset values.
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [2:0] SRC_RST = 3'h0;
	localparam logic [1:0] CLS_RST = 2'h0;
	// Counter clock sources.
	localparam logic [2:0] SRC_DIV12 = 3'h0;
	localparam logic [2:0] SRC_DIV4 = 3'h1;
	localparam logic [2:0] SRC_EXT = 3'h2;
	localparam logic [2:0] SRC_SYS = 3'h3;
	localparam logic [3:0] DIV12_LAST = 4'hb;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	// Cycle length select codes.
	localparam logic [1:0] CLS_8 = 2'h0;
	localparam logic [1:0] CLS_9 = 2'h1;
	localparam logic [1:0] CLS_10 = 2'h2;
	localparam logic [1:0] CLS_11 = 2'h3;
	localparam logic [15:0] MASK_8 = 16'h00ff;
	localparam logic [15:0] MASK_9 = 16'h01ff;
	localparam logic [15:0] MASK_10 = 16'h03ff;
	localparam logic [15:0] MASK_11 = 16'h07ff;
	typedef enum logic [4:0] {
		WM_OFF = 5'h01,
		WM_FREQ = 5'h02,
		WM_PWM8 = 5'h04,
		WM_PWM_ENABLE = 5'h08,
		WM_PWM16 = 5'h10
	} wave_mode_e;
endpackage
